// *** inc/pei_regs.vh ***
/*
 * Constants of the event interrupt status/enable block: management
 * addresses, field positions, reset values and serial frame counts.
 * Assumes it is included by its bare name from the design files.
 */
// What this block does
// - Bit 15 latches link quality change, link up
// - Bit 14 latches energy detect state change
// - Bit 13 latches link up/down change
// - Bit 12 latches resolved speed change
// - Bit 11 latches resolved duplex change
// - Bit 10 latches auto-negotiation completion
// - Bit 9 latches false-carrier counter passing half
// - Bit 8 latches receive-error counter passing half
// - Bit 7 enables link quality interrupt
// - Bit 6 enables energy detect interrupt
// - Bit 5 enables link status interrupt
// - Bit 4 enables speed change interrupt
// - Bit 3 enables duplex change interrupt
// - Bit 2 enables negotiation complete interrupt
// - Bit 1 enables false-carrier half interrupt
// - Bit 0 enables receive-error half interrupt
// - Register at 0x12, resets to zero
// - Global enable gates all event interrupts
// - Polarity one: pin idles high, low active
// - Pin is interrupt output only when enabled
// - Test bit forces interrupt while set
`ifndef PEI_REGS_VH
`define PEI_REGS_VH

// --------------------------------------------------------------
// management addresses
// --------------------------------------------------------------
`define PEI_EVT_ADDR 5'h12
`define PEI_CTL_ADDR 5'h11
`define PEI_BAD_CARRIER_CNT_ADDR 5'h14
`define PEI_RX_ERR_CNT_ADDR 5'h15

// --------------------------------------------------------------
// event register fields
// --------------------------------------------------------------
`define PEI_EVT_RESET 16'h0000
`define PEI_STS_LSB 8
`define PEI_STS_MSB 15
`define PEI_EN_LSB 0
`define PEI_EN_MSB 7
`define PEI_EV_LINK_QUAL 7
`define PEI_EV_ENERGY 6
`define PEI_EV_LINK 5
`define PEI_EV_SPEED 4
`define PEI_EV_DUPLEX 3
`define PEI_EV_AN_DONE 2
`define PEI_EV_BAD_CARRIER 1
`define PEI_EV_RX_ERR 0

// --------------------------------------------------------------
// interrupt control register fields
// --------------------------------------------------------------
`define PEI_CTL_RESET 4'h8
`define PEI_CTL_POL 3
`define PEI_CTL_TEST 2
`define PEI_CTL_GEN 1
`define PEI_CTL_OE 0

// --------------------------------------------------------------
// serial management frame
// --------------------------------------------------------------
`define PEI_PREAMBLE_ONES 6'h20
`define PEI_BIT_HDR_LAST 6'h0d
`define PEI_BIT_TA1 6'h0e
`define PEI_BIT_TA2 6'h0f
`define PEI_BIT_LAST 6'h1f
`define PEI_START 2'h1
`define PEI_OP_WRITE 2'h1
`define PEI_OP_READ 2'h2

`endif

// *** hw/pei_sync.v ***
/*
 * Two flip-flop synchroniser for a group of independent levels.
 * Assumes each bit is a level that may change at any time.
 */
`timescale 1ns/100ps
module pei_sync #(
    parameter WIDTH = 3
) (
    // clock and reset
    input wire core_clk,
    input wire resetn,
    // levels
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_r;
            reg stable_r;
            always @(posedge core_clk) begin
                if (!resetn) begin
                    meta_r <= 1'b1;
                    stable_r <= 1'b1;
                end else begin
                    meta_r <= async_in[i];
                    stable_r <= meta_r;
                end
            end
            assign sync_out[i] = stable_r;
        end
    endgenerate
endmodule // pei_sync

// *** hw/pei_top.v ***
/*
 * Event interrupt status/enable register with its serial management
 * slave, interrupt control bits and the shared interrupt/power-down pin.
 * Assumes event inputs come from logic on core_clk; the management
 * clock, data and the shared pin are asynchronous and are synchronised.
 */
`timescale 1ns/100ps
`include "pei_regs.vh"
module pei_top (
    // clock and reset
    input wire core_clk,
    input wire resetn,
    // station address of this device
    input wire [4:0] phy_addr,
    // link state from the transceiver core
    input wire link_quality_ok,
    input wire energy_detected,
    input wire link_up,
    input wire speed_100,
    input wire full_duplex,
    input wire an_complete,
    // half-full flags of the error counters
    input wire bad_carrier_half,
    input wire rx_err_half,
    // serial management interface
    input wire mdc,
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe_n,
    // shared interrupt / power-down pin
    input wire irq_or_powerdown_pin_in,
    output reg irq_or_powerdown_pin_out,
    output reg irq_or_powerdown_pin_oe_n,
    output reg powerdown_req
);
    // --------------------------------------------------------------
    // frame states
    // --------------------------------------------------------------
    localparam S_PRE = 1'b0;
    localparam S_FRM = 1'b1;

    // --------------------------------------------------------------
    // reset image of the event register
    // --------------------------------------------------------------
    localparam [15:0] EVT_RST = `PEI_EVT_RESET;

    // --------------------------------------------------------------
    // read data of an address
    // --------------------------------------------------------------
    function [15:0] rd_mux;
        input [4:0] addr;
        input [15:0] evt;
        input [3:0] ctl;
        begin
            case (addr)
                `PEI_EVT_ADDR: rd_mux = evt;
                `PEI_CTL_ADDR: rd_mux = {12'h000, ctl};
                default: rd_mux = 16'h0000;
            endcase
        end
    endfunction

    // --------------------------------------------------------------
    // synchronisers
    // --------------------------------------------------------------
    wire [2:0] sync_w;
    wire mdc_s;
    wire mdio_s;
    wire pin_s;

    pei_sync #(
        .WIDTH(3)
    ) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .async_in({irq_or_powerdown_pin_in, mdio_in, mdc}),
        .sync_out(sync_w)
    );

    assign mdc_s = sync_w[0];
    assign mdio_s = sync_w[1];
    assign pin_s = sync_w[2];

    reg mdc_d_r;
    wire mdc_rise;

    always @(posedge core_clk) begin
        if (!resetn) begin
            mdc_d_r <= 1'b1;
        end else begin
            mdc_d_r <= mdc_s;
        end
    end

    assign mdc_rise = mdc_s & ~mdc_d_r;

    // --------------------------------------------------------------
    // event change detection
    // --------------------------------------------------------------
    reg [7:0] lvl_d_r;
    reg lvl_valid_r;
    wire [7:0] lvl_now;
    wire [7:0] hit;

    assign lvl_now = {link_quality_ok, energy_detected, link_up, speed_100,
                      full_duplex, an_complete, bad_carrier_half, rx_err_half};

    always @(posedge core_clk) begin
        if (!resetn) begin
            lvl_d_r <= 8'h00;
            lvl_valid_r <= 1'b0;
        end else begin
            lvl_d_r <= lvl_now;
            lvl_valid_r <= 1'b1;
        end
    end

    // the first cycle after reset only loads the history, no event
    assign hit[`PEI_EV_LINK_QUAL] = lvl_valid_r & link_up &
        (link_quality_ok ^ lvl_d_r[`PEI_EV_LINK_QUAL]);
    assign hit[`PEI_EV_ENERGY] = lvl_valid_r &
        (energy_detected ^ lvl_d_r[`PEI_EV_ENERGY]);
    assign hit[`PEI_EV_LINK] = lvl_valid_r &
        (link_up ^ lvl_d_r[`PEI_EV_LINK]);
    assign hit[`PEI_EV_SPEED] = lvl_valid_r &
        (speed_100 ^ lvl_d_r[`PEI_EV_SPEED]);
    assign hit[`PEI_EV_DUPLEX] = lvl_valid_r &
        (full_duplex ^ lvl_d_r[`PEI_EV_DUPLEX]);
    assign hit[`PEI_EV_AN_DONE] = lvl_valid_r & an_complete &
        ~lvl_d_r[`PEI_EV_AN_DONE];
    assign hit[`PEI_EV_BAD_CARRIER] = lvl_valid_r & bad_carrier_half &
        ~lvl_d_r[`PEI_EV_BAD_CARRIER];
    assign hit[`PEI_EV_RX_ERR] = lvl_valid_r & rx_err_half &
        ~lvl_d_r[`PEI_EV_RX_ERR];

    // --------------------------------------------------------------
    // management frame receiver / transmitter
    // --------------------------------------------------------------
    reg state_r;
    reg [5:0] ones_r;
    reg [5:0] bitn_r;
    reg [15:0] sr_r;
    reg [15:0] tx_r;
    reg is_rd_r;
    reg is_wr_r;
    reg [4:0] reg_r;
    reg rd_clr_r;
    reg wr_stb_r;
    reg [15:0] wr_data_r;
    reg [4:0] wr_addr_r;

    reg [7:0] sts_r;
    reg [7:0] en_r;
    reg [3:0] ctl_r;

    wire [13:0] hdr;
    wire [15:0] din;
    wire [15:0] evt_view;
    wire hdr_ok;

    assign hdr = {sr_r[12:0], mdio_s};
    assign din = {sr_r[14:0], mdio_s};
    assign evt_view = {sts_r, en_r};
    assign hdr_ok = (hdr[13:12] == `PEI_START) && (hdr[9:5] == phy_addr);

    // word handed out at the turnaround; its status half is what a read clears
    wire [15:0] rd_word;
    assign rd_word = rd_mux(reg_r, evt_view, ctl_r);

    always @(posedge core_clk) begin
        if (!resetn) begin
            state_r <= S_PRE;
            ones_r <= 6'h00;
            bitn_r <= 6'h00;
            sr_r <= 16'h0000;
            tx_r <= 16'h0000;
            is_rd_r <= 1'b0;
            is_wr_r <= 1'b0;
            reg_r <= 5'h00;
            rd_clr_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_data_r <= 16'h0000;
            wr_addr_r <= 5'h00;
            mdio_out <= 1'b1;
            mdio_oe_n <= 1'b1;
        end else begin
            rd_clr_r <= 1'b0;
            wr_stb_r <= 1'b0;
            if (mdc_rise) begin
                case (state_r)
                    S_PRE: begin
                        if (mdio_s) begin
                            if (ones_r != `PEI_PREAMBLE_ONES) begin
                                ones_r <= ones_r + 6'h01;
                            end
                        end else if (ones_r == `PEI_PREAMBLE_ONES) begin
                            state_r <= S_FRM;
                            bitn_r <= 6'h01;
                            sr_r <= 16'h0000;
                        end else begin
                            ones_r <= 6'h00;
                        end
                    end
                    S_FRM: begin
                        bitn_r <= bitn_r + 6'h01;
                        sr_r <= din;
                        if (bitn_r == `PEI_BIT_HDR_LAST) begin
                            reg_r <= hdr[4:0];
                            is_rd_r <= hdr_ok && (hdr[11:10] == `PEI_OP_READ);
                            is_wr_r <= hdr_ok && (hdr[11:10] == `PEI_OP_WRITE);
                            if (!hdr_ok) begin
                                state_r <= S_PRE;
                                ones_r <= 6'h00;
                            end
                        end else if (bitn_r == `PEI_BIT_TA1) begin
                            if (is_rd_r) begin
                                mdio_out <= 1'b0;
                                mdio_oe_n <= 1'b0;
                            end
                        end else if (bitn_r == `PEI_BIT_TA2) begin
                            if (is_rd_r) begin
                                tx_r <= rd_word;
                                mdio_out <= rd_word[15];
                                rd_clr_r <= (reg_r == `PEI_EVT_ADDR);
                            end
                        end else if (bitn_r == `PEI_BIT_LAST) begin
                            mdio_out <= 1'b1;
                            mdio_oe_n <= 1'b1;
                            if (is_wr_r) begin
                                wr_stb_r <= 1'b1;
                                wr_data_r <= din;
                                wr_addr_r <= reg_r;
                            end
                            is_rd_r <= 1'b0;
                            is_wr_r <= 1'b0;
                            state_r <= S_PRE;
                            ones_r <= 6'h00;
                        end else if (is_rd_r) begin
                            tx_r <= {tx_r[14:0], 1'b0};
                            mdio_out <= tx_r[14];
                        end
                    end
                    default: begin
                        state_r <= S_PRE;
                        ones_r <= 6'h00;
                    end
                endcase
            end
        end
    end

    // --------------------------------------------------------------
    // event register and interrupt control register
    // --------------------------------------------------------------
    reg [7:0] sts_nxt;

    always @* begin
        sts_nxt = sts_r;
        if (rd_clr_r) begin
            // only the bits the host was shown are cleared, so an event
            // landing on the snapshot edge is not lost
            sts_nxt = sts_r & ~tx_r[15:8];
        end
        // an event in the clearing cycle survives
        sts_nxt = sts_nxt | hit;
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            sts_r <= EVT_RST[`PEI_STS_MSB:`PEI_STS_LSB];
            en_r <= EVT_RST[`PEI_EN_MSB:`PEI_EN_LSB];
            ctl_r <= `PEI_CTL_RESET;
        end else begin
            sts_r <= sts_nxt;
            if (wr_stb_r && (wr_addr_r == `PEI_EVT_ADDR)) begin
                // status half is read-only, only the enables take data
                en_r <= wr_data_r[`PEI_EN_MSB:`PEI_EN_LSB];
            end
            if (wr_stb_r && (wr_addr_r == `PEI_CTL_ADDR)) begin
                ctl_r <= wr_data_r[3:0];
            end
        end
    end

    // --------------------------------------------------------------
    // interrupt pin
    // --------------------------------------------------------------
    wire evt_irq;
    wire irq_active;

    assign evt_irq = ctl_r[`PEI_CTL_GEN] & (|(sts_r & en_r));
    assign irq_active = evt_irq | ctl_r[`PEI_CTL_TEST];

    always @(posedge core_clk) begin
        if (!resetn) begin
            irq_or_powerdown_pin_out <= 1'b1;
            irq_or_powerdown_pin_oe_n <= 1'b1;
            powerdown_req <= 1'b0;
        end else begin
            irq_or_powerdown_pin_out <= ctl_r[`PEI_CTL_POL] ? ~irq_active : irq_active;
            irq_or_powerdown_pin_oe_n <= ~ctl_r[`PEI_CTL_OE];
            // as an input the pin requests power-down when held low
            powerdown_req <= ~ctl_r[`PEI_CTL_OE] & ~pin_s;
        end
    end
endmodule // pei_top

// *** sim/pei_top_properties.sv ***
/*
 * Port-level checker for pei_top: management data line timing,
 * interrupt pin steadiness and the shared power-down pin.
 * Assumes it is bound to pei_top and that mdc runs at 8 core_clk.
 */
`timescale 1ns/100ps
module pei_top_properties (
    // clock and reset
    input wire core_clk,
    input wire resetn,
    // event inputs
    input wire link_quality_ok,
    input wire energy_detected,
    input wire link_up,
    input wire speed_100,
    input wire full_duplex,
    input wire an_complete,
    input wire bad_carrier_half,
    input wire rx_err_half,
    // management interface
    input wire mdc,
    input wire mdio_out,
    input wire mdio_oe_n,
    // shared pin
    input wire irq_or_powerdown_pin_in,
    input wire irq_or_powerdown_pin_out,
    input wire irq_or_powerdown_pin_oe_n,
    input wire powerdown_req
);
    // ----------------------------------------------------------
    // helper logic
    // ----------------------------------------------------------
    wire [7:0] ev = {link_quality_ok, energy_detected, link_up, speed_100,
        full_duplex, an_complete, bad_carrier_half, rx_err_half};
    reg [7:0] ev_r;
    reg mdc_r;
    reg [3:0] quiet_r;
    reg [7:0] low_r;
    always @(posedge core_clk) begin
        ev_r <= ev;
        mdc_r <= mdc;
        // cycles since the last mdc or event change, saturating
        if (!resetn || ev != ev_r || mdc != mdc_r)
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;
        low_r <= (!resetn || mdio_oe_n) ? 8'h00 : low_r + 8'h01;
    end
    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence read_turn;
        !mdio_oe_n && !mdio_out;
    endsequence
    sequence quiet_s;
        quiet_r > 4'ha;
    endsequence
    mdio_idle_a: assert property (mdio_oe_n |-> mdio_out)
        else $error("mdio released but not high");
    mdio_turn_a: assert property ($fell(mdio_oe_n) |-> read_turn)
        else $error("read turnaround not driven low");
    mdio_span_a: assert property ($rose(mdio_oe_n) |-> low_r >= 8'h84 && low_r <= 8'h8c)
        else $error("read drive span wrong");
    mdio_change_a: assert property ($changed({mdio_out, mdio_oe_n}) |->
        $past(mdc, 2) || $past(mdc, 4))
        else $error("mdio moved away from an mdc rise");
    pin_quiet_a: assert property (quiet_s |-> $stable(irq_or_powerdown_pin_out))
        else $error("interrupt pin moved without cause");
    oe_quiet_a: assert property ($changed(irq_or_powerdown_pin_oe_n) |-> quiet_r < 4'h8)
        else $error("pin enable moved without a write");
    oe_pd_a: assert property (!irq_or_powerdown_pin_oe_n |-> !powerdown_req)
        else $error("power-down while pin is an output");
    pd_assert_a: assert property ((irq_or_powerdown_pin_oe_n && !irq_or_powerdown_pin_in)[*5]
        ##1 irq_or_powerdown_pin_oe_n |-> powerdown_req)
        else $error("power-down request missing");
    pd_clear_a: assert property (irq_or_powerdown_pin_in[*5] |-> !powerdown_req)
        else $error("power-down request with pin high");
endmodule // pei_top_properties

bind pei_top pei_top_properties i_pei_top_properties (
    .core_clk(core_clk), .resetn(resetn),
    .link_quality_ok(link_quality_ok), .energy_detected(energy_detected),
    .link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex),
    .an_complete(an_complete), .bad_carrier_half(bad_carrier_half),
    .rx_err_half(rx_err_half), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .irq_or_powerdown_pin_in(irq_or_powerdown_pin_in),
    .irq_or_powerdown_pin_out(irq_or_powerdown_pin_out),
    .irq_or_powerdown_pin_oe_n(irq_or_powerdown_pin_oe_n),
    .powerdown_req(powerdown_req)
);

// *** sim/pei_mdio_host.sv ***
/*
 * Station management host model: whole serial frames on mdc/mdio.
 * Assumes the bench resolves the data line with a pull-up.
 */
`timescale 1ns/100ps
module pei_mdio_host (
    // management clock and host data
    output reg mdc,
    output reg mdio_d,
    output reg mdio_en,
    // resolved data line
    input wire mdio_line
);
    initial begin
        mdc = 1'b0;
        mdio_d = 1'b1;
        mdio_en = 1'b0;
    end
    // data changes while mdc is low, sampled at the rise
    task one_bit(input b, output s);
        begin
            mdio_d = b;
            #80 mdc = 1'b1;
            s = mdio_line;
            #80 mdc = 1'b0;
        end
    endtask
    // mdc stands low outside a frame
    task xfer(input [1:0] op, input [4:0] pa, input [4:0] ra,
        input [15:0] wd, output [15:0] rd);
        reg [31:0] f;
        reg s;
        integer i;
        begin
            f = {2'h1, op, pa, ra, 2'h2, wd};
            #3 mdio_en = 1'b1;
            for (i = 0; i < 32; i = i + 1)
                one_bit(1'b1, s);
            for (i = 31; i >= 0; i = i - 1) begin
                if (op == 2'h2 && i == 17)
                    mdio_en = 1'b0;
                one_bit(f[i], s);
                if (i < 16)
                    rd[i] = s;
            end
            mdio_en = 1'b0;
            #200;
        end
    endtask
endmodule // pei_mdio_host

// *** sim/pei_top_tb_top.sv ***
/*
 * Bench for pei_top: register frames through the host model, event
 * stimulus and pin checks. Assumes pei_regs.vh is on the include path.
 */
`timescale 1ns/100ps
`include "pei_regs.vh"
`define CHK(got, exp) begin \
    n_checks = n_checks + 1; \
    if ((got) !== (exp)) begin \
        failures = failures + 1; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module pei_top_tb_top;
    localparam [4:0] PA = 5'h03;
    reg core_clk = 1'b0;
    reg resetn = 1'b0;
    reg [7:0] ev = 8'ha0;
    reg pin_drv = 1'b1;
    reg [15:0] rx;
    integer failures = 0;
    integer n_checks = 0;
    integer k, p;
    wire mdc, host_d, host_en, mdio_out, mdio_oe_n, pin_out, pin_oe_n, pd_req;
    // pull-up on the data line, pin shared with the bench driver
    wire mdio_line = !mdio_oe_n ? mdio_out : (host_en ? host_d : 1'b1);
    wire pin_in = !pin_oe_n ? pin_out : pin_drv;
    always #10 core_clk = ~core_clk;
    pei_mdio_host i_pei_mdio_host (.mdc(mdc), .mdio_d(host_d), .mdio_en(host_en),
        .mdio_line(mdio_line));
    pei_top i_pei_top (.core_clk(core_clk), .resetn(resetn), .phy_addr(PA),
        .link_quality_ok(ev[7]), .energy_detected(ev[6]), .link_up(ev[5]),
        .speed_100(ev[4]), .full_duplex(ev[3]), .an_complete(ev[2]),
        .bad_carrier_half(ev[1]), .rx_err_half(ev[0]), .mdc(mdc), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .irq_or_powerdown_pin_in(pin_in),
        .irq_or_powerdown_pin_out(pin_out), .irq_or_powerdown_pin_oe_n(pin_oe_n),
        .powerdown_req(pd_req));
    // ----------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------
    task wr(input [4:0] a, input [15:0] d);
        i_pei_mdio_host.xfer(2'h1, PA, a, d, rx);
    endtask
    task rd(input [4:0] a, input [15:0] e);
        begin
            i_pei_mdio_host.xfer(2'h2, PA, a, 16'h0000, rx);
            `CHK(rx, e)
        end
    endtask
    task tick(input [7:0] m);
        begin
            @(negedge core_clk);
            ev = ev ^ m;
            repeat (4) @(negedge core_clk);
        end
    endtask
    // phase 0 toggles each event away from its start level, phase 1 toggles it back
    task ev_step(input integer kk, input integer pp);
        reg [7:0] m;
        reg hit;
        begin
            m = 8'h01 << kk;
            hit = (pp == 0) || (kk >= 3 && kk <= 6);
            wr(`PEI_EVT_ADDR, {8'h00, pp ? m : ~m});
            tick(m);
            `CHK(pin_out, pp ? !hit : 1'b1)
            if (pp == 0) begin
                wr(`PEI_EVT_ADDR, {8'h00, m});
                `CHK(pin_out, 1'b0)
            end
            rd(`PEI_EVT_ADDR, {hit ? m : 8'h00, m});
            `CHK(pin_out, 1'b1)
        end
    endtask
    task print_verdict;
        begin
            $display("checks=%0d failures=%0d", n_checks, failures);
            if (failures == 0 && n_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // ----------------------------------------------------------
    // tests
    // ----------------------------------------------------------
    initial begin
        repeat (20) @(negedge core_clk);
        resetn = 1'b1;
        repeat (4) @(negedge core_clk);
        `CHK({pin_out, pin_oe_n, pd_req}, 3'h6)
        rd(`PEI_EVT_ADDR, 16'h0000);
        rd(`PEI_CTL_ADDR, 16'h0008);
        rd(5'h13, 16'h0000);
        wr(`PEI_EVT_ADDR, 16'hffff);
        rd(`PEI_EVT_ADDR, 16'h00ff);
        i_pei_mdio_host.xfer(2'h1, PA ^ 5'h01, `PEI_EVT_ADDR, 16'h0000, rx);
        i_pei_mdio_host.xfer(2'h2, PA ^ 5'h01, `PEI_EVT_ADDR, 16'h0000, rx);
        `CHK(rx, 16'hffff)
        rd(`PEI_EVT_ADDR, 16'h00ff);
        wr(`PEI_CTL_ADDR, 16'h0009);
        tick(8'h40);
        `CHK({pin_out, pin_oe_n}, 2'h2)
        rd(`PEI_EVT_ADDR, 16'h40ff);
        wr(`PEI_CTL_ADDR, 16'h000b);
        for (p = 0; p < 2; p = p + 1)
            for (k = 7; k >= 0; k = k - 1)
                ev_step(k, p);
        wr(`PEI_CTL_ADDR, 16'h0003);
        `CHK(pin_out, 1'b0)
        wr(`PEI_CTL_ADDR, 16'h0007);
        `CHK(pin_out, 1'b1)
        wr(`PEI_CTL_ADDR, 16'h0000);
        `CHK({pin_oe_n, pd_req}, 2'h2)
        @(negedge core_clk);
        pin_drv = 1'b0;
        repeat (6) @(negedge core_clk);
        `CHK(pd_req, 1'b1)
        pin_drv = 1'b1;
        repeat (6) @(negedge core_clk);
        `CHK(pd_req, 1'b0)
        print_verdict;
    end
    initial begin
        // some 54 frames of about 10.5 us each, with ample margin
        #1000000;
        failures = failures + 1;
        print_verdict;
    end
endmodule // pei_top_tb_top
